// ==== hw/tler_pkg.sv ====
package tler_pkg;
  // 25 MHz clock, 1 ms timebase
  localparam int CLK_HZ = 25000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int HOLD_MS = 3000;
  localparam int BLINK_MS = 250;
  localparam int NUM_LED = 16;
  localparam int NUM_GRP = 10;
  localparam int GRP_W = 16;
  localparam int NUM_PALM = 32;
  localparam int NUM_CALM = 16;
  localparam int NUM_ALM = NUM_PALM + NUM_CALM;
  localparam int LOG_DEPTH = 165;
  localparam int LOG_AW = 8;
  localparam int LOGIC_GRP = 0;
  // register offsets (byte addresses)
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h004;
  localparam logic [11:0] OFS_LEDS = 12'h008;
  localparam logic [11:0] OFS_LATCH = 12'h00C;
  localparam logic [11:0] OFS_TIME = 12'h010;
  localparam logic [11:0] OFS_LOGCNT = 12'h014;
  localparam logic [11:0] OFS_LOGSEL = 12'h018;
  localparam logic [11:0] OFS_LOGTYP = 12'h01C;
  localparam logic [11:0] OFS_LOGVLT = 12'h020;
  localparam logic [11:0] OFS_LOGFLG = 12'h024;
  localparam logic [11:0] OFS_DATE = 12'h028;
  localparam logic [11:0] OFS_LEDCFG = 12'h100;
  localparam logic [11:0] OFS_ALMCFG = 12'h200;
  localparam logic [11:0] OFS_MON = 12'h400;
  // led config fields: [5:0] alarm index, [6] on-inactive, [7] blink, [8] latch
  localparam int LC_POL = 6;
  localparam int LC_BLK = 7;
  localparam int LC_LAT = 8;
  // alarm config fields: [15:0] mask, [19:16] group, [20] and, [21] invert
  localparam int AC_GRP = 16;
  localparam int AC_AND = 20;
  localparam int AC_INV = 21;
  localparam logic [8:0] LC_RST [NUM_LED] = '{
    9'h080, 9'h081, 9'h002, 9'h003, 9'h104, 9'h105, 9'h106, 9'h107,
    9'h108, 9'h109, 9'h08A, 9'h08B, 9'h00C, 9'h00D, 9'h00E, 9'h08F};
  typedef struct packed {
    logic [15:0] mask;
    logic [3:0] grp;
    logic use_and;
    logic inv;
  } tler_alm_s;
  typedef enum logic [1:0] {ST_INIT, ST_RUN, ST_OOS} tler_svc_e;
endpackage

// ==== hw/tler_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - seventeen indicators, one critical bicolour
// - per-led polarity, blink, latch options
// - 32 protection plus 16 comms alarms
// - alarm is OR of selected flags
// - ten groups of sixteen flags
// - one alarm draws from one group
// - one group also allows AND, NOT
// - latched leds survive power cycling
// - button pressed lights every led
// - hold over three seconds clears latches
// - factory default led mapping
// - self-check at start and continuously
// - checks supply and three memories
// - timestamps in one millisecond steps
// - log keeps latest 165 entries
// - entry: time, type, volts, flags
// - monitored flag change creates entry unless out of service
// - log kept in nonvolatile store
// - inhibit and clear flags follow inputs
// - reclose impossible flag per breaker
module tler_top
  import tler_pkg::*;
(
  input wire logic pclk, // 25 MHz
  input wire logic presetn, // async, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [NUM_GRP*GRP_W-1:0] flags, // internal flag matrix
  input wire logic [31:0] volts, // measured voltages, packed
  input wire logic button_n, // test/clear pin, low pressed
  input wire logic [2:0] din_raw, // inhibit b2, common inhibit, lockout clear
  input wire logic [1:0] recl_blocked, // per-breaker reclose impossible
  input wire logic [3:0] chk_fail, // supply, ram, capture_memory, nvm
  input wire logic nv_valid, // retained latch image valid
  input wire logic [NUM_LED-1:0] nv_latch, // retained latch image
  output logic [NUM_LED-1:0] led, // configurable leds
  output logic crit_red, // critical led red half
  output logic crit_green, // critical led green half
  output logic [2:0] din_flag, // direct input flags
  output logic [1:0] recl_imp, // reclose impossible flags
  output logic out_of_service, // unit disabled
  output logic nv_we, // store latch image
  output logic [NUM_LED-1:0] nv_wdata // image to store
);

  ////////////////////////////////////////////////////////////////////
  // synchronisers and millisecond timebase
  logic [3:0] pin_s1, pin_s2;
  logic [1:0] rb_s1, rb_s2;
  logic [15:0] tick_cnt_r;
  logic tick;
  logic pressed;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      // button released, inputs de-energised: no false flags after reset
      pin_s1 <= 4'h8;
      pin_s2 <= 4'h8;
      rb_s1 <= 2'h0;
      rb_s2 <= 2'h0;
    end
    else
    begin
      pin_s1 <= {button_n, din_raw};
      pin_s2 <= pin_s1;
      rb_s1 <= recl_blocked;
      rb_s2 <= rb_s1;
    end
  assign pressed = !pin_s2[3];

  // one pulse each millisecond drives every slower count
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      tick_cnt_r <= 16'h0000;
    else if (tick)
      tick_cnt_r <= 16'h0000;
    else
      tick_cnt_r <= tick_cnt_r + 16'h0001;
  assign tick = (tick_cnt_r == 16'(TICK_CYC - 1));

  // digital inputs energised state, fresh every cycle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      din_flag <= 3'h0;
      recl_imp <= 2'h0;
    end
    else
    begin
      din_flag <= ~pin_s2[2:0] ^ 3'h7;
      recl_imp <= rb_s2;
    end

  ////////////////////////////////////////////////////////////////////
  // configuration storage
  logic [8:0] led_cfg_r [NUM_LED];
  tler_alm_s alm_cfg_r [NUM_ALM];
  logic [NUM_GRP*GRP_W-1:0] mon_mask_r;
  logic [31:0] time_r;
  logic [31:0] date_r;
  logic wr_en, rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;

  // led configuration, factory mapping at reset
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      for (int i = 0; i < NUM_LED; i++)
        led_cfg_r[i] <= LC_RST[i];
    end
    else if (wr_en && paddr[11:8] == OFS_LEDCFG[11:8] && paddr[7:6] == 2'h0)
      led_cfg_r[paddr[5:2]] <= pwdata[8:0];

  // alarm definitions: group, mask, and/or, invert
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      for (int i = 0; i < NUM_ALM; i++)
        alm_cfg_r[i] <= '0;
    end
    else if (wr_en && paddr[11:8] == OFS_ALMCFG[11:8] && paddr[7:2] < 6'(NUM_ALM))
      alm_cfg_r[paddr[7:2]] <= {pwdata[15:0], pwdata[19:16], pwdata[AC_AND], pwdata[AC_INV]};

  // monitored flag selection for logging
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      mon_mask_r <= '0;
    else if (wr_en && paddr[11:8] == OFS_MON[11:8] && paddr[7:2] < 6'(NUM_GRP))
      mon_mask_r[paddr[5:2]*GRP_W +: GRP_W] <= pwdata[15:0];

  // millisecond clock; software may load it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      time_r <= 32'h0000_0000;
      date_r <= 32'h0000_0000;
    end
    else if (wr_en && paddr == OFS_TIME)
      time_r <= pwdata;
    else if (wr_en && paddr == OFS_DATE)
      date_r <= pwdata;
    else if (tick)
      time_r <= time_r + 32'h0000_0001;

  ////////////////////////////////////////////////////////////////////
  // alarm evaluation, one per alarm
  logic [NUM_ALM-1:0] alarm;
  genvar ga;
  generate
    for (ga = 0; ga < NUM_ALM; ga++)
    begin : g_alm
      logic [GRP_W-1:0] sel_grp;
      logic [GRP_W-1:0] term;
      // single group per alarm: no cross-group terms exist in hardware
      assign sel_grp = (alm_cfg_r[ga].grp < 4'(NUM_GRP)) ?
        flags[alm_cfg_r[ga].grp*GRP_W +: GRP_W] : '0;
      // and/not only honoured on the logic group
      assign term = (alm_cfg_r[ga].grp == 4'(LOGIC_GRP) && alm_cfg_r[ga].inv) ?
        ~sel_grp : sel_grp;
      assign alarm[ga] = (alm_cfg_r[ga].grp == 4'(LOGIC_GRP) && alm_cfg_r[ga].use_and) ?
        ((term & alm_cfg_r[ga].mask) == alm_cfg_r[ga].mask && |alm_cfg_r[ga].mask) :
        |(term & alm_cfg_r[ga].mask);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // long press and blink timing
  logic [11:0] hold_r;
  logic clear_pulse;
  logic [8:0] blink_cnt_r;
  logic blink_r;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      hold_r <= 12'h000;
    else if (!pressed)
      hold_r <= 12'h000;
    else if (tick && hold_r <= 12'(HOLD_MS))
      hold_r <= hold_r + 12'h001;
  // fires once when the hold passes three seconds
  assign clear_pulse = tick && pressed && hold_r == 12'(HOLD_MS);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      blink_cnt_r <= 9'h000;
      blink_r <= 1'b0;
    end
    else if (tick)
    begin
      if (blink_cnt_r == 9'(BLINK_MS - 1))
      begin
        blink_cnt_r <= 9'h000;
        blink_r <= !blink_r;
      end
      else
        blink_cnt_r <= blink_cnt_r + 9'h001;
    end

  ////////////////////////////////////////////////////////////////////
  // led state with memory
  logic [NUM_LED-1:0] latch_r;
  logic [NUM_LED-1:0] cond;
  logic restored_r;
  genvar gl;
  generate
    for (gl = 0; gl < NUM_LED; gl++)
    begin : g_led
      assign cond[gl] = alarm[led_cfg_r[gl][5:0] < 6'(NUM_ALM) ? led_cfg_r[gl][5:0] : 6'h00]
        ^ led_cfg_r[gl][LC_POL];
    end
  endgenerate

  // set wins over the clear so a fresh alarm stays visible
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      latch_r <= '0;
      restored_r <= 1'b0;
    end
    else if (!restored_r)
    begin
      restored_r <= 1'b1;
      if (nv_valid)
        latch_r <= nv_latch;
    end
    else
    begin
      for (int i = 0; i < NUM_LED; i++)
        if (led_cfg_r[i][LC_LAT] && cond[i])
          latch_r[i] <= 1'b1;
        else if (clear_pulse || !led_cfg_r[i][LC_LAT])
          latch_r[i] <= 1'b0;
    end

  // image pushed to retained store on change
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      nv_we <= 1'b0;
      nv_wdata <= '0;
    end
    else
    begin
      nv_we <= restored_r && nv_wdata != latch_r;
      nv_wdata <= latch_r;
    end

  // lamp test overrides everything
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      led <= '0;
    else
    begin
      for (int i = 0; i < NUM_LED; i++)
        led[i] <= pressed || ((cond[i] || latch_r[i]) &&
          (!led_cfg_r[i][LC_BLK] || blink_r));
    end

  ////////////////////////////////////////////////////////////////////
  // self-check and service state
  tler_svc_e svc_r;
  logic [3:0] fail_s1, fail_s2, fail_lat_r;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      fail_s1 <= 4'h0;
      fail_s2 <= 4'h0;
    end
    else
    begin
      fail_s1 <= chk_fail;
      fail_s2 <= fail_s1;
    end

  // an internal error is final until reset
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      svc_r <= ST_INIT;
      fail_lat_r <= 4'h0;
    end
    else
    begin
      fail_lat_r <= fail_lat_r | fail_s2;
      case (svc_r)
        ST_INIT: svc_r <= (|fail_s2) ? ST_OOS : (tick ? ST_RUN : ST_INIT);
        ST_RUN: if (|fail_s2) svc_r <= ST_OOS;
        default: svc_r <= ST_OOS;
      endcase
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      out_of_service <= 1'b0;
      crit_red <= 1'b0;
      crit_green <= 1'b0;
    end
    else
    begin
      out_of_service <= svc_r == ST_OOS;
      crit_red <= pressed || svc_r == ST_OOS;
      crit_green <= pressed || svc_r == ST_RUN;
    end

  ////////////////////////////////////////////////////////////////////
  // event recorder, circular store of the newest entries
  logic [31:0] log_time [LOG_DEPTH];
  logic [31:0] log_volt [LOG_DEPTH];
  logic [NUM_GRP*GRP_W-1:0] log_flag [LOG_DEPTH];
  logic [15:0] log_type [LOG_DEPTH];
  logic [NUM_GRP*GRP_W-1:0] flags_q_r;
  logic [NUM_GRP*GRP_W-1:0] chg;
  logic [LOG_AW-1:0] wptr_r;
  logic [LOG_AW-1:0] count_r;
  logic [LOG_AW-1:0] sel_r;
  logic [LOG_AW-1:0] rd_idx;
  logic [4:0] grp_sel_r;
  logic [7:0] first_chg;

  assign chg = (flags ^ flags_q_r) & mon_mask_r;
  // lowest changed monitored flag names the event
  always_comb
  begin
    first_chg = 8'h00;
    for (int i = NUM_GRP*GRP_W - 1; i >= 0; i--)
      if (chg[i])
        first_chg = 8'(i);
  end

  // the storage array stands in for the nonvolatile part: no reset
  always_ff @(posedge pclk)
    if (svc_r != ST_OOS && |chg)
    begin
      log_time[wptr_r] <= time_r;
      log_volt[wptr_r] <= volts;
      log_flag[wptr_r] <= flags;
      log_type[wptr_r] <= {7'h00, flags[first_chg], first_chg};
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      flags_q_r <= '0;
      wptr_r <= 8'h00;
      count_r <= 8'h00;
    end
    else
    begin
      flags_q_r <= flags;
      if (svc_r != ST_OOS && |chg)
      begin
        wptr_r <= (wptr_r == 8'(LOG_DEPTH - 1)) ? 8'h00 : wptr_r + 8'h01;
        if (count_r != 8'(LOG_DEPTH))
          count_r <= count_r + 8'h01;
      end
    end

  // sel 0 is newest entry
  assign rd_idx = (wptr_r > sel_r) ? wptr_r - sel_r - 8'h01 :
    8'(LOG_DEPTH) + wptr_r - sel_r - 8'h01;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sel_r <= 8'h00;
      grp_sel_r <= 5'h00;
    end
    else if (wr_en && paddr == OFS_LOGSEL)
    begin
      sel_r <= (pwdata[7:0] < 8'(LOG_DEPTH)) ? pwdata[7:0] : 8'h00;
      grp_sel_r <= pwdata[12:8];
    end

  ////////////////////////////////////////////////////////////////////
  // apb read mux and error answer
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      if (paddr == OFS_STAT)
        prdata <= {24'h0, fail_lat_r, 1'b0, out_of_service, 2'(svc_r)};
      else if (paddr == OFS_LEDS)
        prdata <= {15'h0, crit_red, led};
      else if (paddr == OFS_LATCH)
        prdata <= {16'h0, latch_r};
      else if (paddr == OFS_TIME)
        prdata <= time_r;
      else if (paddr == OFS_DATE)
        prdata <= date_r;
      else if (paddr == OFS_LOGCNT)
        prdata <= {16'h0, wptr_r, count_r};
      else if (paddr == OFS_LOGSEL)
        prdata <= log_time[rd_idx];
      else if (paddr == OFS_LOGTYP)
        prdata <= {16'h0, log_type[rd_idx]};
      else if (paddr == OFS_LOGVLT)
        prdata <= log_volt[rd_idx];
      else if (paddr == OFS_LOGFLG)
        prdata <= {16'h0, log_flag[rd_idx][(grp_sel_r < 5'(NUM_GRP) ? grp_sel_r : 5'h0)*GRP_W +: GRP_W]};
      else if (paddr[11:8] == OFS_LEDCFG[11:8] && paddr[7:6] == 2'h0)
        prdata <= {23'h0, led_cfg_r[paddr[5:2]]};
      else if (paddr[11:8] == OFS_ALMCFG[11:8] && paddr[7:2] < 6'(NUM_ALM))
        prdata <= {10'h0, alm_cfg_r[paddr[7:2]].inv, alm_cfg_r[paddr[7:2]].use_and,
          alm_cfg_r[paddr[7:2]].grp, alm_cfg_r[paddr[7:2]].mask};
      else if (paddr[11:8] == OFS_MON[11:8] && paddr[7:2] < 6'(NUM_GRP))
        prdata <= {16'h0, mon_mask_r[paddr[5:2]*GRP_W +: GRP_W]};
      else
        prdata <= 32'h0000_0000;
    end

  // unmapped addresses end with an error, data zero
  always_comb
  begin
    pslverr = 1'b0;
    if (psel && penable)
      pslverr = !(paddr == OFS_CTRL || paddr == OFS_STAT || paddr == OFS_LEDS ||
        paddr == OFS_LATCH || paddr == OFS_TIME || paddr == OFS_DATE ||
        paddr == OFS_LOGCNT || paddr == OFS_LOGSEL || paddr == OFS_LOGTYP ||
        paddr == OFS_LOGVLT || paddr == OFS_LOGFLG ||
        (paddr[11:8] == OFS_LEDCFG[11:8] && paddr[7:6] == 2'h0) ||
        (paddr[11:8] == OFS_ALMCFG[11:8] && paddr[7:2] < 6'(NUM_ALM)) ||
        (paddr[11:8] == OFS_MON[11:8] && paddr[7:2] < 6'(NUM_GRP)));
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  a_lamp_test: assert property (@(posedge pclk) disable iff (!presetn)
    pressed |=> &led) else $error("lamp test did not light all leds");
  a_oos_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    svc_r == ST_OOS |=> svc_r == ST_OOS) else $error("left out of service");
  a_fail_oos: assert property (@(posedge pclk) disable iff (!presetn)
    |fail_s2 |=> svc_r == ST_OOS) else $error("error did not stop unit");
  a_log_bound: assert property (@(posedge pclk) disable iff (!presetn)
    count_r <= 8'(LOG_DEPTH) && wptr_r < 8'(LOG_DEPTH)) else $error("log overflow");
  a_log_step: assert property (@(posedge pclk) disable iff (!presetn)
    (svc_r != ST_OOS && |chg && count_r < 8'(LOG_DEPTH)) |=> count_r == $past(count_r) + 8'h01)
    else $error("log count not advanced");
  a_clear_hold: assert property (@(posedge pclk) disable iff (!presetn)
    clear_pulse |-> hold_r == 12'(HOLD_MS) && pressed) else $error("early clear");
  a_din_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 din_flag == $past(pin_s2[2:0])) else $error("input flag lag");
  a_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> !tick) else $error("tick too wide");
  a_imp_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 recl_imp == $past(rb_s2)) else $error("impossible flag lag");

endmodule
`default_nettype wire

// ==== testbench/tler_panel.sv ====
`timescale 1ns/100ps
`default_nettype none
// front panel: operator button and lamp watcher
module tler_panel (
  input wire logic press, // operator holds button
  input wire logic [15:0] led, // configurable lamps
  input wire logic crit_red, // critical lamp red half
  input wire logic crit_green, // critical lamp green half
  output logic button_n, // pin, pulled up when released
  output logic all_lit // every lamp is on
);
  // released pin sits at the pull-up; a clear needs the hold kept past 3 s
  assign button_n = !press;
  // the bicolour lamp counts as lit in either colour
  assign all_lit = (&led) && (crit_red || crit_green);
endmodule
`default_nettype wire

// ==== testbench/tler_top_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tler_top_tb;
  import tler_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, press = 1'b0;
  logic pready, pslverr, button_n, all_lit, crit_red, crit_green, out_of_service, nv_we, perr;
  logic nv_valid = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, volts = 32'h0, prdata, rdv, v, lfsr = 32'h0000A2C3;
  logic [159:0] flags = 160'h0, f;
  logic [2:0] din_raw = 3'h0, din_flag;
  logic [1:0] recl_blocked = 2'h0, recl_imp;
  logic [3:0] chk_fail = 4'h0;
  logic [15:0] nv_latch = 16'h0030, mlat = 16'h0030, mexp, led, nv_wdata, nv_img = 16'h0;
  logic [15:0] tv [8] = '{16'h1, 16'h5, 16'h2, 16'h1, 16'h0, 16'h1, 16'h8000, 16'h0};
  int tg [8] = '{0, 0, 2, 3, 3, 4, 9, 9};
  int n_fail = 0, tests_run = 0, acfg [48], lcfg [16], qv [$], qf [$];

  tler_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .flags, .volts, .button_n, .din_raw, .recl_blocked, .chk_fail, .nv_valid,
    .nv_latch, .led, .crit_red, .crit_green, .din_flag, .recl_imp, .out_of_service, .nv_we,
    .nv_wdata);
  tler_panel panel_u (.press, .led, .crit_red, .crit_green, .button_n, .all_lit);

  // 25 MHz clock; keep the last stored latch image
  always #20 pclk = ~pclk;
  always @(posedge pclk)
    if (nv_we === 1'b1)
      nv_img <= nv_wdata;

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // alarm model; and/invert only honoured in group 0
  function automatic logic alm(input int a, input logic [159:0] fv);
    int g;
    logic [15:0] m;
    logic [15:0] x;
    g = (acfg[a] >> AC_GRP) & 15;
    m = acfg[a][15:0];
    // inversion acts on each selected flag before the and/or
    x = ((acfg[a][AC_INV] && g == 0) ? ~fv[16 * g +: 16] : fv[16 * g +: 16]) & m;
    return (acfg[a][AC_AND] && g == 0) ? (x == m && m != 0) : (x != 0);
  endfunction
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic [31:0] e, input logic [31:0] g);
    chk_reg(nm, e, g);
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    rdv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk_reg(nm, e, rdv);
  endtask
  task automatic setl(input int i, input int d);
    lcfg[i] = d;
    wr(OFS_LEDCFG + 12'(4 * i), d);
  endtask
  task automatic setal(input int a, input int d);
    acfg[a] = d;
    wr(OFS_ALMCFG + 12'(4 * a), d);
  endtask
  // leds are registered: allow a short settling span
  task automatic led_is(input logic [15:0] e);
    for (int k = 0; k < 16 && led !== e; k++)
      @(posedge pclk);
    chk_pin("led", 32'(e), 32'(led));
  endtask
  task automatic step(input logic [159:0] fv);
    logic c;
    @(posedge pclk);
    flags <= fv;
    for (int i = 0; i < NUM_LED; i++)
    begin
      c = alm(lcfg[i] & 63, fv) ^ lcfg[i][LC_POL];
      if (c && lcfg[i][LC_LAT])
        mlat[i] = 1'b1;
      mexp[i] = c | (mlat[i] & lcfg[i][LC_LAT]);
    end
    led_is(mexp);
  endtask
  // toggle one flag with fresh volts; the model keeps the newest entries only
  task automatic evt(input int b, input logic log_it);
    f[b] = ~f[b];
    v = rnd();
    @(posedge pclk);
    flags <= f;
    volts <= v;
    if (log_it)
    begin
      qv.push_front(int'(v));
      qf.push_front(int'(f[95:80]));
    end
    if (qv.size() > LOG_DEPTH)
    begin
      void'(qv.pop_back());
      void'(qf.pop_back());
    end
  endtask
  task automatic lcnt();
    rd(OFS_LOGCNT);
    chk_reg("count", 32'(qv.size()), 32'(rdv[7:0]));
  endtask
  task automatic logchk(input int sel);
    wr(OFS_LOGSEL, 32'h0500 | 32'(sel));
    rdc("volts", OFS_LOGVLT, qv[sel]);
    rdc("flags", OFS_LOGFLG, qf[sel]);
    rd(OFS_LOGTYP);
    chk_reg("level", 32'(qf[sel][8]), 32'(rdv[8]));
    chk_reg("index", 32'h58, 32'(rdv[7:0]));
  endtask

  ////////////////////////////////////////////////////////////////
  // watchdog well beyond the two millisecond waits of the run
  initial
  begin
    repeat (100000) @(posedge pclk);
    n_fail++;
    $display("watchdog expired");
    close_out();
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_LATCH);
    chk_reg("latch", 32'h30, rdv & 32'h30);
    chk_pin("led", 32'h30, 32'(led & 16'h0030));
    rdc("stat", OFS_STAT, 32'h0);
    for (int i = 0; i < NUM_LED; i++)
      rdc("ledcfg", OFS_LEDCFG + 12'(4 * i), 32'(LC_RST[i]));
    rd(12'h800);
    chk_reg("slverr", 32'h1, 32'(perr));
    chk_reg("unmapped", 32'h0, rdv);
    $display("test reset done");
    // steady lamps only: blinking would make the sample time matter
    for (int a = 0; a < NUM_ALM; a++)
      setal(a, 0);
    for (int i = 0; i < NUM_LED; i++)
      setl(i, (i == 4 || i == 5) ? int'(LC_RST[i]) : i);
    setl(3, 32'h043);
    setl(6, 32'h106);
    setl(12, 32'h028);
    setal(1, 32'h0020_0001);
    setal(2, 32'h0010_0005);
    setal(3, 32'h0002_0003);
    setal(6, 32'h0003_0001);
    setal(40, 32'h0009_8000);
    f = 160'h0;
    step(f);
    for (int k = 0; k < 8; k++)
    begin
      f[16 * tg[k] +: 16] = tv[k];
      step(f);
    end
    chk_reg("nvimg", 32'h70, 32'(nv_img));
    rdc("latch", OFS_LATCH, 32'h70);
    $display("test alarms done");
    @(posedge pclk);
    press <= 1'b1;
    for (int k = 0; k < 8 && all_lit !== 1'b1; k++)
      @(posedge pclk);
    chk_pin("lamp", 32'h1, 32'(all_lit));
    @(posedge pclk);
    press <= 1'b0;
    led_is(mexp);
    $display("test lamp done");
    for (int k = 0; k < 4; k++)
    begin
      rdv = rnd();
      @(posedge pclk);
      din_raw <= rdv[2:0];
      recl_blocked <= rdv[4:3];
      repeat (4) @(posedge pclk);
      chk_pin("din", 32'(rdv[2:0]), 32'(din_flag));
      chk_pin("recl", 32'(rdv[4:3]), 32'(recl_imp));
    end
    $display("test inputs done");
    // start-up check ends at the first tick; time then counts whole ticks
    rdv = 32'h0;
    for (int k = 0; k < 12000 && rdv[1:0] !== 2'h1; k++)
      rd(OFS_STAT);
    chk_reg("svc", 32'h1, rdv);
    chk_pin("crit", 32'h1, 32'({crit_red, crit_green}));
    repeat (100) @(posedge pclk);
    wr(OFS_TIME, 32'h64);
    repeat (TICK_CYC) @(posedge pclk);
    rdc("time", OFS_TIME, 32'h65);
    $display("test time done");
    wr(OFS_MON + 12'h014, 32'h0100);
    evt(88, 1'b1);
    lcnt();
    logchk(0);
    evt(80, 1'b0);
    lcnt();
    for (int k = 0; k < 170; k++)
      evt(88, 1'b1);
    lcnt();
    logchk(0);
    logchk(164);
    $display("test log done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge pclk);
      chk_fail <= 4'(1 << i);
      rdv = 32'h0;
      for (int k = 0; k < 8 && rdv[4 + i] !== 1'b1; k++)
        rd(OFS_STAT);
      chk_reg("stat", {24'h0, 4'((2 << i) - 1), 4'h6}, {24'h0, rdv[7:4], 1'b0, rdv[2:0]});
      chk_pin("oos", 32'h1, 32'(out_of_service));
      chk_pin("crit", 32'h2, 32'({crit_red, crit_green}));
    end
    evt(88, 1'b0);
    logchk(0);
    $display("test selfcheck done");
    close_out();
  end
endmodule
`default_nettype wire
